// [src/spc_pkg.sv]
// Shared constants and types for the secondary poll/connect command block
package spc_pkg;
  localparam logic [7:0] CMD_POLL   = 8'h03;
  localparam logic [7:0] CMD_CONN   = 8'h04;
  localparam logic [7:0] CMD_DISC   = 8'h05;
  localparam logic [7:0] ADDR_BCAST = 8'hff;
  localparam logic [7:0] ADDR_NONE  = 8'h00;
  localparam logic [7:0] ADDR_FIRST = 8'h01;
  localparam logic [7:0] ADDR_LAST  = 8'hfe;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned CLK_HZ    = 25_000_000;
  localparam int unsigned TIMEOUT_S = 4;
  localparam int unsigned TIMEOUT_CYC = CLK_HZ * TIMEOUT_S;
  typedef enum logic [1:0] {
    OP_POLL,
    OP_CONN,
    OP_DISC
  } spc_op_e;
endpackage : spc_pkg

// [src/spc_tbl_if.sv]
// Carrier between command logic and the on-line table memory
`timescale 1ns/1ns
`default_nettype none
interface spc_tbl_if #(parameter int unsigned AW = 8);
  logic          we;
  logic [AW-1:0] waddr;
  logic          wdata;
  logic [AW-1:0] raddr;
  logic          rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : spc_tbl_if
`default_nettype wire

// [src/spc_tbl_mem.sv]
// One bit per secondary address: set while that secondary is connected
`timescale 1ns/1ns
`default_nettype none
module spc_tbl_mem #(
  parameter int unsigned AW = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  spc_tbl_if.mem   tbl
);
  localparam int unsigned DEPTH = 1 << AW;
  logic [DEPTH-1:0] bits_ff;
  logic [DEPTH-1:0] nxt_bits;
  logic             rdata_ff;
  logic             nxt_rdata;

  if (AW < 1 || AW > 12) begin : g_chk
    $error("spc_tbl_mem: AW out of range");
  end

  always_comb begin
    nxt_bits = bits_ff;
    if (tbl.we) begin
      nxt_bits[tbl.waddr] = tbl.wdata;
    end
    nxt_rdata = bits_ff[tbl.raddr];
  end

  // Cleared on reset so nothing counts as connected at power-up
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bits_ff  <= '0;
      rdata_ff <= 1'b0;
    end else begin
      bits_ff  <= nxt_bits;
      rdata_ff <= nxt_rdata;
    end
  end

  assign tbl.rdata = rdata_ff;
endmodule : spc_tbl_mem
`default_nettype wire

// [src/spc_timer.sv]
// Give-up timer for a secondary that does not answer
`timescale 1ns/1ns
`default_nettype none
module spc_timer #(
  parameter int unsigned CYC = 100_000_000
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic start_in,
  input  wire logic stop_in,
  output var  logic expire_out
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic        run_ff;
  logic        nxt_run;
  logic        exp_ff;
  logic        nxt_exp;

  if (CYC < 1) begin : g_chk
    $error("spc_timer: CYC must be at least 1");
  end

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    nxt_exp = 1'b0;
    if (start_in) begin
      nxt_cnt = CYC - 32'h1;
      nxt_run = 1'b1;
    end else if (stop_in) begin
      nxt_run = 1'b0;
    end else if (run_ff) begin
      if (cnt_ff == 32'h0) begin
        nxt_exp = 1'b1;
        nxt_run = 1'b0;
      end else begin
        nxt_cnt = cnt_ff - 32'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_ff <= 32'h0;
      run_ff <= 1'b0;
      exp_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
      exp_ff <= nxt_exp;
    end
  end

  assign expire_out = exp_ff;
endmodule : spc_timer
`default_nettype wire

// [src/spc_cmd_top.sv]
// Poll, connect and disconnect command interpreter for network secondaries
//
// Behaviour
// - Poll code solicits one secondary's answer
// - Poll reply: code, address, primitive data
// - Connect code attaches each listed secondary
// - Connect without addresses raises error
// - Broadcast connect polls all, reports on-line
// - No connection gives single 00 field
// - Absent secondary costs four seconds wait
// - Connect reply: code then connected addresses
// - Disconnect code detaches each listed secondary
// - Disconnect without addresses raises error
// - Broadcast disconnect re-polls, reports off-line
// - No disconnection gives single 00 field
`timescale 1ns/1ns
`default_nettype none
module spc_cmd_top #(
  parameter int unsigned TIMEOUT_CYC = spc_pkg::TIMEOUT_CYC
) (
  input  wire logic                        CLK_IN,
  input  wire logic                        SYS_RST_IN,
  input  wire logic [7:0]                  HOST_RX_DATA_IN,
  input  wire logic                        HOST_RX_VALID_IN,
  input  wire logic                        HOST_RX_LAST_IN,
  output var  logic                        HOST_RX_READY_OUT,
  output var  logic [7:0]                  HOST_TX_DATA_OUT,
  output var  logic                        HOST_TX_VALID_OUT,
  input  wire logic                        HOST_TX_READY_IN,
  output var  logic                        HOST_TX_DONE_OUT,
  output var  logic                        CMD_ERR_OUT,
  output var  logic                        NET_REQ_OUT,
  output var  spc_pkg::spc_op_e            NET_OP_OUT,
  output var  logic [spc_pkg::ADDR_W-1:0]  NET_ADDR_OUT,
  input  wire logic                        NET_ACK_IN,
  input  wire logic [spc_pkg::DATA_W-1:0]  NET_DATA_IN
);
  import spc_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_SCAN, ST_CHK, ST_REQ, ST_WAIT,
    ST_NEXT, ST_PRSP, ST_FIN, ST_TX, ST_SKIP
  } spc_state_e;

  spc_state_e        state_ff, nxt_state, ret_ff, nxt_ret;
  logic [7:0]        code_ff, nxt_code;
  logic [7:0]        addr_ff, nxt_addr;
  logic [DATA_W-1:0] data_ff, nxt_data;
  logic [1:0]        seq_ff, nxt_seq;
  logic              last_ff, nxt_last;
  logic              any_ff, nxt_any;
  logic              bcast_ff, nxt_bcast;
  logic [7:0]        tx_data_ff, nxt_tx_data;
  logic              tx_valid_ff, nxt_tx_valid;
  logic              done_ff, nxt_done;
  logic              err_ff, nxt_err;
  logic              req_ff, nxt_req;
  spc_op_e           op_ff, nxt_op;
  logic              rx_ready_ff, nxt_rx_ready;
  logic              rx_take;
  logic              expire;

  spc_tbl_if #(.AW(ADDR_W)) tbl ();

  spc_tbl_mem #(.AW(ADDR_W)) u_mem (
    .clk_in (CLK_IN),
    .rst_in (SYS_RST_IN),
    .tbl    (tbl)
  );

  spc_timer #(.CYC(TIMEOUT_CYC)) u_timer (
    .clk_in     (CLK_IN),
    .rst_in     (SYS_RST_IN),
    .start_in   (req_ff),
    .stop_in    (NET_ACK_IN),
    .expire_out (expire)
  );

  function automatic logic is_cmd(input logic [7:0] c);
    return (c == CMD_POLL) || (c == CMD_CONN) || (c == CMD_DISC);
  endfunction : is_cmd

  // one byte per code or address
  assign rx_take = HOST_RX_VALID_IN && rx_ready_ff;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state    = state_ff;
    nxt_ret      = ret_ff;
    nxt_code     = code_ff;
    nxt_addr     = addr_ff;
    nxt_data     = data_ff;
    nxt_seq      = seq_ff;
    nxt_last     = last_ff;
    nxt_any      = any_ff;
    nxt_bcast    = bcast_ff;
    nxt_tx_data  = tx_data_ff;
    nxt_tx_valid = tx_valid_ff;
    nxt_op       = op_ff;
    nxt_done     = 1'b0;
    nxt_err      = 1'b0;
    nxt_req      = 1'b0;
    tbl.we       = 1'b0;
    tbl.waddr    = addr_ff;
    tbl.wdata    = 1'b0;
    tbl.raddr    = addr_ff;
    case (state_ff)
      ST_IDLE: begin
        if (rx_take) begin
          nxt_code  = HOST_RX_DATA_IN;
          nxt_last  = HOST_RX_LAST_IN;
          nxt_any   = 1'b0;
          nxt_bcast = 1'b0;
          if (!is_cmd(HOST_RX_DATA_IN)) begin
            // Foreign codes belong to other handlers; drop their bytes
            nxt_state = HOST_RX_LAST_IN ? ST_IDLE : ST_SKIP;
          end else if (HOST_RX_LAST_IN) begin
            nxt_err = 1'b1;
          end else if (HOST_RX_DATA_IN == CMD_POLL) begin
            nxt_state = ST_ADDR;
          end else begin
            nxt_tx_data  = HOST_RX_DATA_IN;
            nxt_tx_valid = 1'b1;
            nxt_ret      = ST_ADDR;
            nxt_state    = ST_TX;
          end
        end
      end
      ST_ADDR: begin
        if (rx_take) begin
          nxt_addr = HOST_RX_DATA_IN;
          nxt_last = HOST_RX_LAST_IN;
          if (HOST_RX_DATA_IN == ADDR_BCAST && code_ff != CMD_POLL) begin
            // trailing addresses after broadcast are skipped
            nxt_bcast = 1'b1;
            nxt_addr  = ADDR_FIRST;
            nxt_state = ST_SCAN;
          end else begin
            nxt_state = ST_REQ;
          end
        end
      end
      ST_SCAN: begin
        // Table read takes one cycle; disconnect only probes known members
        nxt_state = (code_ff == CMD_DISC) ? ST_CHK : ST_REQ;
      end
      ST_CHK: begin
        nxt_state = tbl.rdata ? ST_REQ : ST_NEXT;
      end
      ST_REQ: begin
        nxt_req   = 1'b1;
        nxt_op    = (bcast_ff || code_ff == CMD_POLL) ? OP_POLL :
                    (code_ff == CMD_CONN) ? OP_CONN : OP_DISC;
        nxt_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (NET_ACK_IN) begin
          nxt_data = NET_DATA_IN;
          if (code_ff == CMD_POLL) begin
            nxt_tx_data  = code_ff;
            nxt_tx_valid = 1'b1;
            nxt_seq      = 2'h0;
            nxt_ret      = ST_PRSP;
            nxt_state    = ST_TX;
          end else if (bcast_ff && code_ff == CMD_DISC) begin
            nxt_state = ST_NEXT;
          end else begin
            tbl.we       = 1'b1;
            tbl.wdata    = (code_ff == CMD_CONN);
            nxt_any      = 1'b1;
            nxt_tx_data  = addr_ff;
            nxt_tx_valid = 1'b1;
            nxt_ret      = ST_NEXT;
            nxt_state    = ST_TX;
          end
        end else if (expire) begin
          if (code_ff == CMD_POLL) begin
            nxt_err   = 1'b1;
            nxt_state = last_ff ? ST_IDLE : ST_SKIP;
          end else if (bcast_ff && code_ff == CMD_DISC) begin
            // silent member goes to the off-line list
            tbl.we       = 1'b1;
            tbl.wdata    = 1'b0;
            nxt_any      = 1'b1;
            nxt_tx_data  = addr_ff;
            nxt_tx_valid = 1'b1;
            nxt_ret      = ST_NEXT;
            nxt_state    = ST_TX;
          end else begin
            nxt_state = ST_NEXT;
          end
        end
      end
      ST_NEXT: begin
        if (bcast_ff && addr_ff != ADDR_LAST) begin
          nxt_addr  = addr_ff + 8'h01;
          nxt_state = ST_SCAN;
        end else if (!bcast_ff && !last_ff) begin
          nxt_state = ST_ADDR;
        end else if (!any_ff) begin
          nxt_tx_data  = ADDR_NONE;
          nxt_tx_valid = 1'b1;
          nxt_ret      = ST_FIN;
          nxt_state    = ST_TX;
        end else begin
          nxt_state = ST_FIN;
        end
      end
      ST_PRSP: begin
        nxt_seq      = seq_ff + 2'h1;
        nxt_tx_valid = 1'b1;
        nxt_ret      = ST_PRSP;
        nxt_state    = ST_TX;
        case (seq_ff)
          2'h0: nxt_tx_data = addr_ff;
          2'h1: nxt_tx_data = data_ff[15:8];
          2'h2: nxt_tx_data = data_ff[7:0];
          default: begin
            nxt_tx_valid = 1'b0;
            nxt_state    = ST_FIN;
          end
        endcase
      end
      ST_FIN: begin
        nxt_done  = 1'b1;
        nxt_state = last_ff ? ST_IDLE : ST_SKIP;
      end
      ST_TX: begin
        if (HOST_TX_READY_IN) begin
          nxt_tx_valid = 1'b0;
          nxt_state    = ret_ff;
        end
      end
      ST_SKIP: begin
        if (rx_take && HOST_RX_LAST_IN) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    nxt_rx_ready = (nxt_state == ST_IDLE) || (nxt_state == ST_ADDR) ||
                   (nxt_state == ST_SKIP);
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      state_ff    <= ST_IDLE;
      ret_ff      <= ST_IDLE;
      code_ff     <= 8'h00;
      addr_ff     <= 8'h00;
      data_ff     <= '0;
      seq_ff      <= 2'h0;
      last_ff     <= 1'b0;
      any_ff      <= 1'b0;
      bcast_ff    <= 1'b0;
      tx_data_ff  <= 8'h00;
      tx_valid_ff <= 1'b0;
      done_ff     <= 1'b0;
      err_ff      <= 1'b0;
      req_ff      <= 1'b0;
      op_ff       <= OP_POLL;
      rx_ready_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      ret_ff      <= nxt_ret;
      code_ff     <= nxt_code;
      addr_ff     <= nxt_addr;
      data_ff     <= nxt_data;
      seq_ff      <= nxt_seq;
      last_ff     <= nxt_last;
      any_ff      <= nxt_any;
      bcast_ff    <= nxt_bcast;
      tx_data_ff  <= nxt_tx_data;
      tx_valid_ff <= nxt_tx_valid;
      done_ff     <= nxt_done;
      err_ff      <= nxt_err;
      req_ff      <= nxt_req;
      op_ff       <= nxt_op;
      rx_ready_ff <= nxt_rx_ready;
    end
  end

  assign HOST_RX_READY_OUT = rx_ready_ff;
  assign HOST_TX_DATA_OUT  = tx_data_ff;
  assign HOST_TX_VALID_OUT = tx_valid_ff;
  assign HOST_TX_DONE_OUT  = done_ff;
  assign CMD_ERR_OUT       = err_ff;
  assign NET_REQ_OUT       = req_ff;
  assign NET_OP_OUT        = op_ff;
  assign NET_ADDR_OUT      = addr_ff;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  a_poll_solicit: assert property (
    state_ff == ST_ADDR && rx_take && code_ff == CMD_POLL
    |-> ##2 NET_REQ_OUT && NET_OP_OUT == OP_POLL && NET_ADDR_OUT == $past(HOST_RX_DATA_IN, 2))
    else $error("poll not sent to the given secondary");
  a_poll_reply: assert property (
    state_ff == ST_WAIT && NET_ACK_IN && code_ff == CMD_POLL
    |=> HOST_TX_VALID_OUT && HOST_TX_DATA_OUT == CMD_POLL)
    else $error("poll reply does not open with its code");
  a_conn_attach: assert property (
    state_ff == ST_ADDR && rx_take && code_ff == CMD_CONN && HOST_RX_DATA_IN != ADDR_BCAST
    |-> ##2 NET_REQ_OUT && NET_OP_OUT == OP_CONN)
    else $error("connect request not issued");
  a_conn_empty: assert property (
    state_ff == ST_IDLE && rx_take && HOST_RX_LAST_IN && HOST_RX_DATA_IN == CMD_CONN
    |=> CMD_ERR_OUT ##1 (!CMD_ERR_OUT || $past(rx_take)))
    else $error("empty connect did not flag one error pulse");
  a_bcast_poll: assert property (
    state_ff == ST_ADDR && rx_take && code_ff == CMD_CONN && HOST_RX_DATA_IN == ADDR_BCAST
    |-> ##3 NET_REQ_OUT && NET_OP_OUT == OP_POLL && NET_ADDR_OUT == ADDR_FIRST)
    else $error("broadcast connect did not start polling");
  a_conn_none: assert property (
    state_ff == ST_NEXT && code_ff == CMD_CONN && !any_ff && (bcast_ff ? addr_ff == ADDR_LAST : last_ff)
    |=> HOST_TX_VALID_OUT && HOST_TX_DATA_OUT == ADDR_NONE)
    else $error("missing 00 field after empty connect");
  a_conn_header: assert property (
    state_ff == ST_IDLE && rx_take && !HOST_RX_LAST_IN && HOST_RX_DATA_IN == CMD_CONN
    |=> HOST_TX_VALID_OUT && HOST_TX_DATA_OUT == CMD_CONN)
    else $error("connect reply does not open with its code");
  a_disc_detach: assert property (
    state_ff == ST_ADDR && rx_take && code_ff == CMD_DISC && HOST_RX_DATA_IN != ADDR_BCAST
    |-> ##2 NET_REQ_OUT && NET_OP_OUT == OP_DISC)
    else $error("disconnect request not issued");
  a_disc_empty: assert property (
    state_ff == ST_IDLE && rx_take && HOST_RX_LAST_IN && HOST_RX_DATA_IN == CMD_DISC
    |=> CMD_ERR_OUT)
    else $error("empty disconnect did not flag an error");
  a_disc_rescan: assert property (
    state_ff == ST_ADDR && rx_take && code_ff == CMD_DISC && HOST_RX_DATA_IN == ADDR_BCAST
    |=> state_ff == ST_SCAN && NET_ADDR_OUT == ADDR_FIRST ##1 state_ff == ST_CHK)
    else $error("broadcast disconnect did not start the re-poll");
  a_disc_none: assert property (
    state_ff == ST_NEXT && code_ff == CMD_DISC && !any_ff && (bcast_ff ? addr_ff == ADDR_LAST : last_ff)
    |=> HOST_TX_VALID_OUT && HOST_TX_DATA_OUT == ADDR_NONE)
    else $error("missing 00 field after empty disconnect");

  c_poll_done:  cover property (state_ff == ST_PRSP && seq_ff == 2'h3);
  c_bcast_conn: cover property (bcast_ff && code_ff == CMD_CONN && HOST_TX_DONE_OUT);
  c_bcast_disc: cover property (bcast_ff && code_ff == CMD_DISC && expire);
  c_empty_err:  cover property (CMD_ERR_OUT);
endmodule : spc_cmd_top
`default_nettype wire

// [test/spc_net_model.sv]
// Behavioural model of the network secondaries behind the command block
`timescale 1ns/1ns
`default_nettype none
module spc_net_model (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         req_in,
  input  wire logic         slow_in,
  input  wire logic [7:0]   addr_in,
  input  wire logic [255:0] present_in,
  output var  logic         ack_out,
  output var  logic [15:0]  data_out
);
  logic [3:0]  wait_ff;
  logic [7:0]  addr_ff;
  logic [15:0] junk_ff;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wait_ff <= 4'h0;
      ack_out <= 1'b0;
      addr_ff <= 8'h00;
      junk_ff <= 16'h5a5a;
    end else begin
      // Idle data bus keeps moving, never a stale answer
      junk_ff <= {junk_ff[14:0], ~junk_ff[15]};
      ack_out <= (wait_ff == 4'h1);
      if (req_in && present_in[addr_in]) begin
        wait_ff <= slow_in ? 4'h8 : 4'h2;
        addr_ff <= addr_in;
      end else if (wait_ff != 4'h0) begin
        wait_ff <= wait_ff - 4'h1;
      end
    end
  end
  assign data_out = ack_out ? {addr_ff, ~addr_ff} : junk_ff;
endmodule : spc_net_model
`default_nettype wire

// [test/tb_spc_cmd_top.sv]
// Self-checking bench for the poll, connect and disconnect interpreter
`timescale 1ns/1ns
`default_nettype none
module tb_spc_cmd_top;
  import spc_pkg::*;
  typedef logic [7:0] spc_bq_t[$];
  localparam int unsigned TO_CYC = 20;
  localparam int          CEIL   = 40000;
  logic           clk, rst, rx_valid, rx_last, rx_ready, tx_valid, tx_ready;
  logic           tx_done, cmd_err, net_req, net_ack, slow;
  logic [7:0]     rx_data, tx_data, net_addr;
  logic [15:0]    net_data;
  logic [255:0]   present, conn;
  logic [31:0]    lfsr     = 32'h363c;
  logic [31:0]    rdy_lfsr = 32'h363c;
  logic [7:0]     a0, a1;
  spc_op_e        net_op, exp_op;
  spc_bq_t        got, none, cmd;
  int             err_total, checked, cyc, done_cnt, err_cnt, t0;
  ////////////////////////////////////////////////////////////////////////////
  spc_cmd_top #(.TIMEOUT_CYC(TO_CYC)) spc_cmd_top_i (
    .CLK_IN(clk), .SYS_RST_IN(rst), .HOST_RX_DATA_IN(rx_data),
    .HOST_RX_VALID_IN(rx_valid), .HOST_RX_LAST_IN(rx_last),
    .HOST_RX_READY_OUT(rx_ready), .HOST_TX_DATA_OUT(tx_data),
    .HOST_TX_VALID_OUT(tx_valid), .HOST_TX_READY_IN(tx_ready),
    .HOST_TX_DONE_OUT(tx_done), .CMD_ERR_OUT(cmd_err), .NET_REQ_OUT(net_req),
    .NET_OP_OUT(net_op), .NET_ADDR_OUT(net_addr), .NET_ACK_IN(net_ack),
    .NET_DATA_IN(net_data));
  spc_net_model spc_net_model_i (
    .clk_in(clk), .rst_in(rst), .req_in(net_req), .slow_in(slow),
    .addr_in(net_addr), .present_in(present), .ack_out(net_ack),
    .data_out(net_data));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0400_0007 : 32'h0);
  endfunction : lfsr_next

  function automatic spc_bq_t exp_poll(input logic [7:0] a);
    return present[a] ? spc_bq_t'{CMD_POLL, a, a, ~a} : spc_bq_t'{};
  endfunction : exp_poll

  // Reply list; also tracks which secondaries stand connected
  function automatic spc_bq_t exp_list(input spc_bq_t c);
    spc_bq_t r;
    r.push_back(c[0]);
    if (c[1] == ADDR_BCAST) begin
      for (int a = ADDR_FIRST; a <= ADDR_LAST; a++) begin
        if (c[0] == CMD_CONN && present[a]) begin
          r.push_back(8'(a));
          conn[a] = 1'b1;
        end
        if (c[0] == CMD_DISC && conn[a] && !present[a]) begin
          r.push_back(8'(a));
          conn[a] = 1'b0;
        end
      end
    end else begin
      for (int i = 1; i < c.size(); i++) begin
        if (present[c[i]]) begin
          r.push_back(c[i]);
          conn[c[i]] = (c[0] == CMD_CONN);
        end
      end
    end
    if (r.size() == 1) begin
      r.push_back(ADDR_NONE);
    end
    return r;
  endfunction : exp_list

  // Bounded search so a thin pattern cannot freeze time
  function automatic logic [7:0] pick(input logic want);
    logic [7:0] a;
    int         k;
    k = 0;
    do begin
      lfsr = lfsr_next(lfsr);
      a    = lfsr[7:0];
      k++;
    end while ((present[a] != want || a == ADDR_NONE || a == ADDR_BCAST) && k < 4096);
    return a;
  endfunction : pick

  task automatic check(input logic ok, input string what);
    checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // Each byte stands until the edge that takes it
  task automatic send_cmd(input spc_bq_t b);
    foreach (b[i]) begin
      rx_valid = 1'b1;
      rx_data  = b[i];
      rx_last  = (i == b.size() - 1);
      do @(posedge clk); while (!rx_ready);
      #1;
    end
    rx_valid = 1'b0;
    rx_last  = 1'b0;
  endtask : send_cmd

  // Kind: 0 reply and done, 1 error only, 2 silently swallowed
  task automatic run_cmd(input spc_bq_t c, input spc_bq_t e, input int kind);
    got.delete();
    done_cnt = 0;
    err_cnt  = 0;
    exp_op   = (c[0] == CMD_POLL || (c.size() > 1 && c[1] == ADDR_BCAST)) ? OP_POLL :
               (c[0] == CMD_CONN) ? OP_CONN : OP_DISC;
    send_cmd(c);
    if (kind == 2) begin
      repeat (10) @(posedge clk);
    end else begin
      while (done_cnt + err_cnt == 0) @(posedge clk);
    end
    repeat (3) @(posedge clk);
    #1;
    check(got == e && done_cnt == int'(kind == 0) && err_cnt == int'(kind == 1),
          "reply bytes or end pulse");
  endtask : run_cmd
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    rdy_lfsr <= lfsr_next(rdy_lfsr);
    tx_ready <= #1 rdy_lfsr[2] | rdy_lfsr[5];
  end

  always @(posedge clk) begin
    cyc++;
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
    if (tx_done) begin
      done_cnt++;
    end
    if (cmd_err) begin
      err_cnt++;
    end
    if (net_req) begin
      check(net_op == exp_op, "network op");
    end
    if (cyc == CEIL) begin
      err_total++;
      $display("MISMATCH %0t cycle limit reached", $time);
      print_verdict();
    end
  end

  initial begin
    rst      = 1'b1;
    rx_valid = 1'b0;
    rx_last  = 1'b0;
    rx_data  = 8'h00;
    slow     = 1'b0;
    conn     = '0;
    for (int i = 0; i < 256; i++) begin
      lfsr       = lfsr_next(lfsr);
      present[i] = lfsr[7] | lfsr[3];
    end
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    run_cmd(spc_bq_t'{CMD_CONN}, none, 1);
    run_cmd(spc_bq_t'{CMD_DISC}, none, 1);
    run_cmd(spc_bq_t'{8'h02, 8'h11}, none, 2);
    a0 = pick(1'b1);
    run_cmd(spc_bq_t'{CMD_POLL, a0}, exp_poll(a0), 0);
    a0 = pick(1'b0);
    t0 = cyc;
    run_cmd(spc_bq_t'{CMD_POLL, a0}, none, 1);
    check(cyc - t0 > TO_CYC && cyc - t0 < TO_CYC + 20, "give-up wait length");
    for (int n = 0; n < 6; n++) begin
      slow = lfsr[9];
      a0   = pick(lfsr[4]);
      a1   = pick(lfsr[6]);
      cmd  = spc_bq_t'{CMD_CONN, a0, a1};
      run_cmd(cmd, exp_list(cmd), 0);
      run_cmd(spc_bq_t'{CMD_POLL, a0}, exp_poll(a0), present[a0] ? 0 : 1);
      cmd  = spc_bq_t'{CMD_DISC, a1};
      run_cmd(cmd, exp_list(cmd), 0);
    end
    a0 = pick(1'b0);
    run_cmd(spc_bq_t'{CMD_CONN, a0}, spc_bq_t'{CMD_CONN, ADDR_NONE}, 0);
    run_cmd(spc_bq_t'{CMD_DISC, a0}, spc_bq_t'{CMD_DISC, ADDR_NONE}, 0);
    cmd = spc_bq_t'{CMD_CONN, ADDR_BCAST};
    run_cmd(cmd, exp_list(cmd), 0);
    // Unplug about half, then let the re-poll find them
    for (int i = 0; i < 256; i++) begin
      lfsr       = lfsr_next(lfsr);
      present[i] = present[i] & lfsr[5];
    end
    cmd = spc_bq_t'{CMD_DISC, ADDR_BCAST};
    run_cmd(cmd, exp_list(cmd), 0);
    // Reset in mid-run must forget every connection
    rst  = 1'b1;
    conn = '0;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    run_cmd(cmd, spc_bq_t'{CMD_DISC, ADDR_NONE}, 0);
    print_verdict();
  end
endmodule : tb_spc_cmd_top
`default_nettype wire
